// ### tsc_defs.svh
`ifndef TSC_DEFS_SVH
`define TSC_DEFS_SVH

// register word addresses
`define TSC_REG_CTRL 4'h0
`define TSC_REG_STATUS 4'h1
`define TSC_REG_ANGLE 4'h2
`define TSC_REG_RAW 4'h3
`define TSC_REG_WORDS 4'h4

// control fields
`define TSC_CTRL_START 0
`define TSC_CTRL_CONT 1
`define TSC_CTRL_RATIO_LO 2
`define TSC_CTRL_RATIO_HI 3
`define TSC_CTRL_SAMPLING 4
`define TSC_CTRL_BUSY_ONLY 5
`define TSC_CTRL_FWIDTH_LO 8
`define TSC_CTRL_FWIDTH_HI 11
`define TSC_FWIDTH_RESET 4'hE
`define TSC_FWIDTH_MAX 4'hE

// status fields
`define TSC_STAT_ACTIVE 0
`define TSC_STAT_DONE 1
`define TSC_STAT_BUSY 2
`define TSC_STAT_READY 3

// speed ratio codes
`define TSC_RATIO_36_1 2'h0
`define TSC_RATIO_18_1 2'h1
`define TSC_RATIO_36_2 2'h2
`define TSC_RATIO_9_1 2'h3

// timing
`define TSC_CLK_PERIOD_NS 50
`define TSC_CONV_TIME_NS 320
`define TSC_CONV_CYC \
    ((`TSC_CONV_TIME_NS + `TSC_CLK_PERIOD_NS - 1) / `TSC_CLK_PERIOD_NS)
`define TSC_INH_TIME_NS 3000
`define TSC_INH_CYC \
    ((`TSC_INH_TIME_NS + `TSC_CLK_PERIOD_NS - 1) / `TSC_CLK_PERIOD_NS)
`define TSC_ACCESS_CYC 2

`endif

// ### tsc_pkg.sv
package tsc_pkg;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_INHIBIT,
        ST_CONVERT,
        ST_ENABLE,
        ST_GAP,
        ST_DONE
    } tsc_state_t;

    typedef enum logic [1:0] {
        GRP_HIGH,
        GRP_MID,
        GRP_LOW
    } tsc_group_t;
endpackage

// ### tsc_input_stage.sv
`timescale 1ns/1ps
`include "tsc_defs.svh"
module tsc_input_stage
    import tsc_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic load,
    input wire logic [6:0] coarse_word,
    input wire logic [13:0] fine_word,
    input wire logic [1:0] ratio,
    input wire logic [3:0] fine_width,
    output logic [6:0] coarse_angle_in,
    output logic [13:0] fine_angle_in
);
    logic [6:0] coarse_d;
    logic [13:0] fine_d;
    logic [6:0] cmask;
    logic [13:0] fmask;
    logic [3:0] width;

    always_comb begin
        cmask = 7'h7F;
        if (ratio == `TSC_RATIO_18_1 || ratio == `TSC_RATIO_36_2) begin
            cmask = 7'h3F; // R8 R9
        end else if (ratio == `TSC_RATIO_9_1) begin
            cmask = 7'h1F; // R10
        end
        width = fine_width;
        if (width == 4'h0 || width > `TSC_FWIDTH_MAX) begin
            width = `TSC_FWIDTH_MAX;
        end
        fmask = 14'h3FFF << (`TSC_FWIDTH_MAX - width); // R11
        coarse_d = coarse_angle_in;
        fine_d = fine_angle_in;
        if (load) begin
            coarse_d = coarse_word & cmask;
            fine_d = fine_word & fmask;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            coarse_angle_in <= 7'h00;
            fine_angle_in <= 14'h0000;
        end else begin
            coarse_angle_in <= coarse_d;
            fine_angle_in <= fine_d;
        end
    end
endmodule

// ### tsc_regs.sv
`timescale 1ns/1ps
`include "tsc_defs.svh"
module tsc_regs
    import tsc_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic [3:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    input wire logic active,
    input wire logic busy_any,
    input wire logic ready_all,
    input wire logic done_pulse,
    input wire logic [19:0] angle,
    input wire logic [19:0] raw,
    input wire logic [6:0] coarse_seen,
    input wire logic [13:0] fine_seen,
    output logic start,
    output logic continuous,
    output logic [1:0] ratio,
    output logic sampling,
    output logic busy_only,
    output logic [3:0] fine_width
);
    logic [31:0] rdata_d;
    logic start_d, cont_d, samp_d, bonly_d, done_q, done_d;
    logic [1:0] ratio_d;
    logic [3:0] fwidth_d;

    always_comb begin
        start_d = 1'b0;
        cont_d = continuous;
        ratio_d = ratio;
        samp_d = sampling;
        bonly_d = busy_only;
        fwidth_d = fine_width;
        done_d = done_q;
        rdata_d = 32'h0000_0000;
        if (wr && addr == `TSC_REG_CTRL) begin
            start_d = wdata[`TSC_CTRL_START];
            cont_d = wdata[`TSC_CTRL_CONT];
            ratio_d = wdata[`TSC_CTRL_RATIO_HI:`TSC_CTRL_RATIO_LO];
            samp_d = wdata[`TSC_CTRL_SAMPLING];
            bonly_d = wdata[`TSC_CTRL_BUSY_ONLY];
            fwidth_d = wdata[`TSC_CTRL_FWIDTH_HI:`TSC_CTRL_FWIDTH_LO];
        end else if (wr && addr == `TSC_REG_STATUS) begin
            if (wdata[`TSC_STAT_DONE]) begin
                done_d = 1'b0;
            end
        end
        // set wins over clear
        if (done_pulse) begin
            done_d = 1'b1;
        end
        if (rd) begin
            if (addr == `TSC_REG_CTRL) begin
                rdata_d[`TSC_CTRL_CONT] = continuous;
                rdata_d[`TSC_CTRL_RATIO_HI:`TSC_CTRL_RATIO_LO] = ratio;
                rdata_d[`TSC_CTRL_SAMPLING] = sampling;
                rdata_d[`TSC_CTRL_BUSY_ONLY] = busy_only;
                rdata_d[`TSC_CTRL_FWIDTH_HI:`TSC_CTRL_FWIDTH_LO] = fine_width;
            end else if (addr == `TSC_REG_STATUS) begin
                rdata_d[`TSC_STAT_ACTIVE] = active;
                rdata_d[`TSC_STAT_DONE] = done_q;
                rdata_d[`TSC_STAT_BUSY] = busy_any;
                rdata_d[`TSC_STAT_READY] = ready_all;
            end else if (addr == `TSC_REG_ANGLE) begin
                rdata_d[19:0] = angle;
            end else if (addr == `TSC_REG_RAW) begin
                rdata_d[19:0] = raw;
            end else if (addr == `TSC_REG_WORDS) begin
                rdata_d[13:0] = fine_seen;
                rdata_d[22:16] = coarse_seen;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rdata <= 32'h0000_0000;
            start <= 1'b0;
            continuous <= 1'b0;
            ratio <= `TSC_RATIO_36_1;
            sampling <= 1'b0;
            busy_only <= 1'b0;
            fine_width <= `TSC_FWIDTH_RESET;
            done_q <= 1'b0;
        end else begin
            rdata <= rdata_d;
            start <= start_d;
            continuous <= cont_d;
            ratio <= ratio_d;
            sampling <= samp_d;
            busy_only <= bonly_d;
            fine_width <= fwidth_d;
            done_q <= done_d;
        end
    end
endmodule

// ### tsc_host.sv
`timescale 1ns/1ps
`include "tsc_defs.svh"
// Summary of operation
// R1: coarse word drives seven coarse inputs, MSB first
// R2: fine word drives fourteen fine inputs, MSB first
// R3: twenty-bit result read back, bit one MSB
// R4: high enable low reads bits one-four
// R5: middle enable low reads bits five-twelve
// R6: low enable low reads bits thirteen-twenty
// R7: full parallel output needs all enables low
// R8: 18:1 ties coarse MSB low
// R9: 36:2 same wiring, MSB weighs 90 degrees
// R10: 9:1 ties two coarse MSBs low
// R11: unused fine LSBs tied low
// R12: inputs held stable during combining
// R13: result valid 320 ns after inputs
// R14: inhibit both, wait ORed busy clear
// R15: sampling: AND ready, or OR busy
// R16: never more than one group enabled
// R17: misalignment up to 90 fine degrees corrected
// R18: coarse times 36, compared, corrected
// R19: joined words divided by 36
// R20: combining path has no storage
module tsc_host
    import tsc_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic [3:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    input wire logic [6:0] coarse_word,
    input wire logic [13:0] fine_word,
    input wire logic coarse_converter_busy,
    input wire logic fine_converter_busy,
    input wire logic coarse_data_ready,
    input wire logic fine_data_ready,
    output logic converter_inhibit_n,
    output logic [6:0] coarse_angle_in,
    output logic [13:0] fine_angle_in,
    output logic high_group_enable_n,
    output logic middle_group_enable_n,
    output logic low_group_enable_n,
    input wire logic [7:0] data_bus
);
    ////////////////////////////////////////////////////////////////////////
    // configuration and status registers

    logic start, continuous, sampling, busy_only, done_pulse;
    logic [1:0] ratio;
    logic [3:0] fine_width;
    logic [19:0] angle_q, angle_d, raw_q, raw_d;
    tsc_state_t state_q, state_d;
    tsc_group_t grp_q, grp_d;
    logic [6:0] cnt_q, cnt_d;
    logic inh_n_d, load;
    logic high_en_n_d, mid_en_n_d, low_en_n_d;
    logic busy_any, ready_all, stable, last_grp;

    tsc_regs u_regs (
        .clk(clk),
        .resetn(resetn),
        .addr(addr),
        .wdata(wdata),
        .wr(wr),
        .rd(rd),
        .rdata(rdata),
        .active(state_q != ST_IDLE),
        .busy_any(busy_any),
        .ready_all(ready_all),
        .done_pulse(done_pulse),
        .angle(angle_q),
        .raw(raw_q),
        .coarse_seen(coarse_angle_in),
        .fine_seen(fine_angle_in),
        .start(start),
        .continuous(continuous),
        .ratio(ratio),
        .sampling(sampling),
        .busy_only(busy_only),
        .fine_width(fine_width)
    );

    ////////////////////////////////////////////////////////////////////////
    // latched words toward the combiner

    tsc_input_stage u_stage (
        .clk(clk),
        .resetn(resetn),
        .load(load),
        .coarse_word(coarse_word),
        .fine_word(fine_word),
        .ratio(ratio),
        .fine_width(fine_width),
        .coarse_angle_in(coarse_angle_in),
        .fine_angle_in(fine_angle_in)
    );

    ////////////////////////////////////////////////////////////////////////
    // transfer sequencer

    assign busy_any = coarse_converter_busy | fine_converter_busy; // R14
    assign ready_all = coarse_data_ready & fine_data_ready; // R15
    assign last_grp = (grp_q == GRP_LOW);

    always_comb begin
        stable = !busy_any; // R14
        if (sampling && !busy_only) begin
            stable = ready_all; // R15
        end
    end

    always_comb begin
        state_d = state_q;
        grp_d = grp_q;
        cnt_d = cnt_q;
        raw_d = raw_q;
        angle_d = angle_q;
        inh_n_d = converter_inhibit_n;
        high_en_n_d = 1'b1;
        mid_en_n_d = 1'b1;
        low_en_n_d = 1'b1;
        load = 1'b0;
        done_pulse = 1'b0;
        case (state_q)
            ST_IDLE: begin
                inh_n_d = 1'b1;
                cnt_d = 7'h00;
                if (start || continuous) begin
                    state_d = ST_INHIBIT;
                    inh_n_d = sampling;
                end
            end
            ST_INHIBIT: begin
                // tracking: give the holding latch its time first
                if (cnt_q != 7'(`TSC_INH_CYC) && !sampling) begin
                    cnt_d = cnt_q + 7'h01;
                end else if (stable) begin
                    load = 1'b1; // R12
                    cnt_d = 7'h00;
                    state_d = ST_CONVERT;
                end
            end
            ST_CONVERT: begin
                cnt_d = cnt_q + 7'h01;
                if (cnt_q == 7'(`TSC_CONV_CYC - 1)) begin
                    cnt_d = 7'h00;
                    grp_d = GRP_HIGH;
                    state_d = ST_ENABLE; // R13
                end
            end
            ST_ENABLE: begin
                cnt_d = cnt_q + 7'h01;
                high_en_n_d = !(grp_q == GRP_HIGH); // R4 R7 R16
                mid_en_n_d = !(grp_q == GRP_MID); // R5 R16
                low_en_n_d = !(grp_q == GRP_LOW); // R6 R16
                if (cnt_q == 7'(`TSC_ACCESS_CYC)) begin
                    high_en_n_d = 1'b1;
                    mid_en_n_d = 1'b1;
                    low_en_n_d = 1'b1;
                    cnt_d = 7'h00;
                    state_d = ST_GAP;
                    if (grp_q == GRP_HIGH) begin
                        raw_d[19:16] = data_bus[3:0]; // R3 R4
                    end else if (grp_q == GRP_MID) begin
                        raw_d[15:8] = data_bus; // R5
                    end else begin
                        raw_d[7:0] = data_bus; // R6
                    end
                end
            end
            ST_GAP: begin
                // bus recovery between groups
                if (last_grp) begin
                    state_d = ST_DONE;
                end else begin
                    grp_d = (grp_q == GRP_HIGH) ? GRP_MID : GRP_LOW;
                    state_d = ST_ENABLE;
                end
            end
            ST_DONE: begin
                inh_n_d = 1'b1;
                done_pulse = 1'b1;
                state_d = ST_IDLE;
                // left-justify so the MSB always weighs the top bit
                if (ratio == `TSC_RATIO_9_1) begin
                    angle_d = {raw_q[17:0], 2'b00}; // R10
                end else if (ratio == `TSC_RATIO_36_1) begin
                    angle_d = raw_q;
                end else begin
                    angle_d = {raw_q[18:0], 1'b0}; // R8 R9
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_q <= ST_IDLE;
            grp_q <= GRP_HIGH;
            cnt_q <= 7'h00;
            raw_q <= 20'h00000;
            angle_q <= 20'h00000;
            converter_inhibit_n <= 1'b1;
            high_group_enable_n <= 1'b1;
            middle_group_enable_n <= 1'b1;
            low_group_enable_n <= 1'b1;
        end else begin
            state_q <= state_d;
            grp_q <= grp_d;
            cnt_q <= cnt_d;
            raw_q <= raw_d;
            angle_q <= angle_d;
            converter_inhibit_n <= inh_n_d;
            high_group_enable_n <= high_en_n_d;
            middle_group_enable_n <= mid_en_n_d;
            low_group_enable_n <= low_en_n_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks

    logic [7:0] since_load_q;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            since_load_q <= 8'h00;
        end else if (load) begin
            since_load_q <= 8'h00;
        end else if (since_load_q != 8'hFF) begin
            since_load_q <= since_load_q + 8'h01;
        end
    end

    one_group_a: assert property (@(posedge clk) disable iff (!resetn) // R16
        $onehot0({~high_group_enable_n, ~middle_group_enable_n,
                  ~low_group_enable_n}))
        else $error("more than one output group enabled");

    conv_wait_a: assert property (@(posedge clk) disable iff (!resetn) // R13
        $fell(high_group_enable_n) |-> since_load_q >= 8'd7)
        else $error("high group read before conversion time");

    stable_in_a: assert property (@(posedge clk) disable iff (!resetn) // R12
        (state_q inside {ST_CONVERT, ST_ENABLE, ST_GAP})
            |=> $stable(coarse_angle_in) && $stable(fine_angle_in))
        else $error("combiner inputs changed mid transfer");

    inhibit_hold_a: assert property (@(posedge clk) disable iff (!resetn)// R14
        (load && !sampling) |=> !converter_inhibit_n [*8])
        else $error("inhibit released during transfer");

    load_ok_a: assert property (@(posedge clk) disable iff (!resetn) // R15
        load |-> ((sampling && !busy_only) ? ready_all : !busy_any))
        else $error("words taken while converters unsettled");

    coarse_tie_a: assert property (@(posedge clk) disable iff (!resetn) // R8
        (load && ratio != `TSC_RATIO_36_1) |=> !coarse_angle_in[6])
        else $error("coarse MSB not tied low");

    nine_tie_a: assert property (@(posedge clk) disable iff (!resetn) // R10
        (load && ratio == `TSC_RATIO_9_1) |=> coarse_angle_in[6:5] == 2'b00)
        else $error("coarse top bits not tied low");

    fine_tie_a: assert property (@(posedge clk) disable iff (!resetn) // R11
        (load && fine_width == 4'hA) |=> fine_angle_in[3:0] == 4'h0)
        else $error("unused fine bits not tied low");

    done_seq_a: assert property (@(posedge clk) disable iff (!resetn) // R3
        $fell(low_group_enable_n) |-> ##4 $rose(converter_inhibit_n)
            || sampling)
        else $error("transfer did not finish after low group");

    grp_pulse_a: assert property (@(posedge clk) disable iff (!resetn) // R4
        $fell(high_group_enable_n) |=> !high_group_enable_n
            ##1 high_group_enable_n)
        else $error("high group enable not two cycles low");

    mid_next_a: assert property (@(posedge clk) disable iff (!resetn) // R5
        $rose(high_group_enable_n) |-> ##2 $fell(middle_group_enable_n))
        else $error("middle group not read after high group");

    low_next_a: assert property (@(posedge clk) disable iff (!resetn) // R6
        $rose(middle_group_enable_n) |-> ##2 $fell(low_group_enable_n))
        else $error("low group not read after middle group");

    bus_take_a: assert property (@(posedge clk) disable iff (!resetn) // R3
        (state_q == ST_ENABLE && cnt_q == 7'(`TSC_ACCESS_CYC))
            |-> !(high_group_enable_n && middle_group_enable_n
                  && low_group_enable_n))
        else $error("bus sampled with no group enabled");

    track_inh_a: assert property (@(posedge clk) disable iff (!resetn) // R14
        (state_q == ST_INHIBIT && !sampling) |-> !converter_inhibit_n)
        else $error("converters not inhibited while waiting");

    samp_free_a: assert property (@(posedge clk) disable iff (!resetn) // R15
        (load && sampling) |=> converter_inhibit_n)
        else $error("sampling converters inhibited");

    inh_free_a: assert property (@(posedge clk) disable iff (!resetn) // R14
        done_pulse |=> converter_inhibit_n)
        else $error("inhibit held after transfer");
endmodule

// ### tsc_combiner_model.sv
`timescale 1ns/1ps
module tsc_combiner_model (
    input wire logic [6:0] coarse_angle_in,
    input wire logic [13:0] fine_angle_in,
    input wire logic high_group_enable_n,
    input wire logic middle_group_enable_n,
    input wire logic low_group_enable_n,
    output logic [7:0] data_bus
);
    logic [19:0] comb_now;
    logic [19:0] angle_out;
    logic [2:0] en_n;
    logic idle_tog = 1'b0;
    int turns;
    int total;
    ////////////////////////////////////////////////////////////////////////
    // released lines wander so a stale value never looks valid
    always #35 idle_tog = ~idle_tog;
    // coarse rescaled by 36, snapped to the fine word, divided back down
    always_comb begin
        turns = int'(coarse_angle_in) * 4608 + 2304;
        turns = (turns - int'(fine_angle_in) + 8192 + 589824) / 16384;
        turns = turns % 36;
        total = turns * 16384 + int'(fine_angle_in);
        comb_now = 20'((total * 16) / 9);
    end
    // inertial delay: old answer until inputs have been steady 320 ns
    assign #320 angle_out = comb_now;
    ////////////////////////////////////////////////////////////////////////
    assign en_n = {high_group_enable_n, middle_group_enable_n,
                   low_group_enable_n};
    always_comb begin
        case (en_n)
            3'b011: data_bus = {4'hA ^ {4{idle_tog}}, angle_out[19:16]};
            3'b101: data_bus = angle_out[15:8];
            3'b110: data_bus = angle_out[7:0];
            3'b111: data_bus = 8'h5A ^ {8{idle_tog}};
            default: data_bus = 8'hXX;
        endcase
    end
endmodule

// ### two_speed_angle_combiner_tb.sv
`timescale 1ns/1ps
`include "tsc_defs.svh"
module two_speed_angle_combiner_tb;
    typedef struct {
        logic [1:0] ratio;
        logic smp;
        logic bo;
        logic [3:0] fw;
        int t;
        int d;
    } tsc_row_t;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [31:0] rdata;
    logic [6:0] coarse_word = 7'h00;
    logic [13:0] fine_word = 14'h0000;
    logic c_busy = 1'b0;
    logic f_busy = 1'b0;
    logic c_rdy = 1'b0;
    logic f_rdy = 1'b0;
    logic converter_inhibit_n;
    logic [6:0] coarse_angle_in;
    logic [13:0] fine_angle_in;
    logic high_group_enable_n;
    logic middle_group_enable_n;
    logic low_group_enable_n;
    logic [7:0] data_bus;
    int error_cnt = 0;
    int checks = 0;
    time t_chg = 0;
    tsc_row_t rows [8];
    tsc_row_t r;
    int pos;
    logic [6:0] cw;
    logic [6:0] cm;
    logic [13:0] fm;
    logic [19:0] raw;
    logic [19:0] ang;
    logic [31:0] v;
    logic [31:0] ctrl;
    ////////////////////////////////////////////////////////////////////////
    always #25 clk = ~clk;
    tsc_host dut (.clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .coarse_word(coarse_word),
        .fine_word(fine_word), .coarse_converter_busy(c_busy),
        .fine_converter_busy(f_busy), .coarse_data_ready(c_rdy),
        .fine_data_ready(f_rdy), .converter_inhibit_n(converter_inhibit_n),
        .coarse_angle_in(coarse_angle_in), .fine_angle_in(fine_angle_in),
        .high_group_enable_n(high_group_enable_n),
        .middle_group_enable_n(middle_group_enable_n),
        .low_group_enable_n(low_group_enable_n), .data_bus(data_bus));
    tsc_combiner_model partner (.coarse_angle_in(coarse_angle_in),
        .fine_angle_in(fine_angle_in),
        .high_group_enable_n(high_group_enable_n),
        .middle_group_enable_n(middle_group_enable_n),
        .low_group_enable_n(low_group_enable_n), .data_bus(data_bus));
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        d = rdata;
        @(posedge clk);
    endtask
    task automatic wait_done;
        logic [31:0] s;
        int i;
        s = 32'h0;
        for (i = 0; i < 300 && s[`TSC_STAT_DONE] !== 1'b1; i++) begin
            rd_reg(`TSC_REG_STATUS, s);
        end
        check("done", 32'(s[`TSC_STAT_DONE]), 32'h1);
        wr_reg(`TSC_REG_STATUS, 32'h2);
    endtask
    ////////////////////////////////////////////////////////////////////////
    // bus reads only after settled inputs, one group at a time
    always @(coarse_angle_in or fine_angle_in) t_chg = $time;
    always @(negedge clk) begin
        if (resetn && !(high_group_enable_n && middle_group_enable_n
                        && low_group_enable_n)) begin
            check("enables", 32'(high_group_enable_n)
                + 32'(middle_group_enable_n) + 32'(low_group_enable_n),
                32'h2);
            check("settle", 32'($time - t_chg >= 320), 32'h1);
        end
    end
    // reckoned from about 1000 cycles of tests, with wide margin
    initial begin
        #(20000 * 50);
        error_cnt++;
        report_and_stop;
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        rows = '{'{2'h0, 1'b0, 1'b0, 4'hE, 0, 0},
                 '{2'h0, 1'b0, 1'b0, 4'hE, 589823, 4000},
                 '{2'h0, 1'b0, 1'b0, 4'hE, 100000, -4096},
                 '{2'h0, 1'b1, 1'b0, 4'hE, 300001, 2500},
                 '{2'h1, 1'b1, 1'b1, 4'hE, 200000, 0},
                 '{2'h2, 1'b0, 1'b0, 4'hE, 294000, 0},
                 '{2'h3, 1'b0, 1'b0, 4'hE, 147000, 0},
                 '{2'h0, 1'b0, 1'b0, 4'hA, 320005, -1000}};
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        foreach (rows[i]) begin
            r = rows[i];
            pos = ((r.t + r.d) % 589824 + 589824) % 589824;
            cw = 7'(pos / 4608);
            cm = (r.ratio == 2'h3) ? 7'h1F : (r.ratio != 2'h0) ? 7'h3F : 7'h7F;
            fm = 14'h3FFF << (14 - int'(r.fw));
            raw = 20'(((r.t / 16384) * 16384
                + int'(14'(r.t % 16384) & fm)) * 16 / 9);
            ang = raw << ((r.ratio == 2'h3) ? 2 : (r.ratio != 2'h0) ? 1 : 0);
            coarse_word <= cw;
            fine_word <= 14'(r.t % 16384);
            c_rdy <= 1'b1;
            f_rdy <= 1'b1;
            ctrl = (32'(r.fw) << 8) | (32'(r.bo) << 5) | (32'(r.smp) << 4);
            wr_reg(`TSC_REG_CTRL, ctrl | (32'(r.ratio) << 2) | 32'h1);
            wait_done;
            rd_reg(`TSC_REG_ANGLE, v);
            check("angle", v, 32'(ang));
            rd_reg(`TSC_REG_RAW, v);
            check("raw", v, 32'(raw));
            rd_reg(`TSC_REG_WORDS, v);
            check("words", v, {9'h0, cw & cm, 2'h0,
                14'(r.t % 16384) & fm});
        end
        // second reset in mid-run, then reset values and unmapped place
        c_rdy <= 1'b0;
        f_rdy <= 1'b0;
        @(posedge clk);
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        check("rst rdata", rdata, 32'h0);
        check("rst outs", {converter_inhibit_n, high_group_enable_n,
            middle_group_enable_n, low_group_enable_n, coarse_angle_in,
            fine_angle_in}, 32'h1E00000);
        @(posedge clk);
        resetn <= 1'b1;
        rd_reg(`TSC_REG_CTRL, v);
        check("ctrl rst", v, 32'h00000E00);
        rd_reg(`TSC_REG_STATUS, v);
        check("status rst", v, 32'h0);
        wr_reg(4'hF, 32'hFFFFFFFF);
        rd_reg(4'hF, v);
        check("unmapped", v, 32'h0);
        rd_reg(`TSC_REG_CTRL, v);
        check("ctrl kept", v, 32'h00000E00);
        // tracking: held busy keeps the read off past the inhibit wait
        c_busy <= 1'b1;
        wr_reg(`TSC_REG_CTRL, 32'h00000E01);
        repeat (100) @(posedge clk);
        #1;
        check("inhibit", 32'(converter_inhibit_n), 32'h0);
        check("no read", 32'(high_group_enable_n), 32'h1);
        rd_reg(`TSC_REG_STATUS, v);
        check("busy or", v, 32'h5);
        c_busy <= 1'b0;
        wait_done;
        check("released", 32'(converter_inhibit_n), 32'h1);
        // sampling: one converter ready is not enough
        c_rdy <= 1'b1;
        wr_reg(`TSC_REG_CTRL, 32'h00000E11);
        repeat (40) @(posedge clk);
        #1;
        check("no inhibit", 32'(converter_inhibit_n), 32'h1);
        check("no read", 32'(high_group_enable_n), 32'h1);
        rd_reg(`TSC_REG_STATUS, v);
        check("ready and", v, 32'h1);
        f_rdy <= 1'b1;
        wait_done;
        // continuous: next transfer starts by itself until cleared
        wr_reg(`TSC_REG_CTRL, 32'h00000E02);
        wait_done;
        wr_reg(`TSC_REG_CTRL, 32'h00000E00);
        rd_reg(`TSC_REG_STATUS, v);
        check("rerun", v, 32'h9);
        wait_done;
        rd_reg(`TSC_REG_STATUS, v);
        check("stopped", v, 32'h8);
        report_and_stop;
    end
endmodule
